// >>> rmf_pkg.sv
// Constants for the reference monitor failure status and mask bank.
// Assumes a 32-bit AXI4-Lite register bus; every register sits in one word.

package rmf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NREF  = 4;   // Reference inputs
  localparam int NFLAG = 4;   // Failure flags per reference
  localparam int NGPIO = 8;   // General purpose pins usable for loss input
  localparam int SELW  = 3;   // Pin index width
  localparam int AW    = 8;   // Bus address width
  localparam int IDXW  = 5;   // Register index width

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDXW-1:0] IDX_ISR_STATUS = 5'h02;
  localparam logic [IDXW-1:0] IDX_ISR_MASK   = 5'h04;
  localparam logic [IDXW-1:0] IDX_STAT_UPPER = 5'h06;
  localparam logic [IDXW-1:0] IDX_STAT_LOWER = 5'h07;
  localparam logic [IDXW-1:0] IDX_MASK_UPPER = 5'h08;
  localparam logic [IDXW-1:0] IDX_MASK_LOWER = 5'h09;
  localparam logic [IDXW-1:0] IDX_PIN_SELECT = 5'h10;

  // ----------------------------------------------------------------
  // Flag positions inside one four-bit reference group
  // ----------------------------------------------------------------
  localparam int FLAG_SIGNAL_LOSS  = 0;
  localparam int FLAG_SINGLE_CYCLE = 1;
  localparam int FLAG_COARSE_FREQ  = 2;
  localparam int FLAG_SOAK_EXPIRED = 3;
  localparam int UPPER_PAIR_LSB    = 8;   // Refs 2 and 3 in the 16-bit vectors

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_STATUS     = 8'h00;
  localparam logic [7:0]  RST_MON_MASK   = 8'h66;
  localparam logic [3:0]  RST_ISR        = 4'h0;
  localparam logic [3:0]  RST_ISR_MASK   = 4'h0;
  localparam logic [11:0] RST_PIN_SELECT = 12'h688;  // Ref n on pin n

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> rmf_los_sel.sv
// Signal-loss pin routing: synchronises the general purpose pins and
// routes one of them to each reference, reporting rising edges.
// Assumes pins are asynchronous to aclk; select comes from aclk logic.

`timescale 1ns/100ps

module rmf_los_sel (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [rmf_pkg::NGPIO-1:0]             gpio_in,
  input  wire logic [rmf_pkg::NREF*rmf_pkg::SELW-1:0] pin_select,
  output logic      [rmf_pkg::NREF-1:0]              loss_rise
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser on every pin
  // ----------------------------------------------------------------
  logic [rmf_pkg::NGPIO-1:0] meta_r;
  logic [rmf_pkg::NGPIO-1:0] sync_r;
  logic [rmf_pkg::NREF-1:0]  level_nxt;
  logic [rmf_pkg::NREF-1:0]  level_r;
  logic [rmf_pkg::NREF-1:0]  rise_nxt;
  logic [rmf_pkg::NREF-1:0]  rise_r;

  // Only the second stage feeds logic, keeping metastability contained
  always_ff @(posedge aclk) begin
    meta_r <= gpio_in;
    sync_r <= meta_r;
  end

  // ----------------------------------------------------------------
  // Per-reference pin mux and edge detect
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < rmf_pkg::NREF; g++) begin : g_ref
      assign level_nxt[g] = sync_r[pin_select[g*rmf_pkg::SELW +: rmf_pkg::SELW]];
    end
  endgenerate

  // A reselect onto a high pin counts as a new loss edge; that is intended
  assign rise_nxt = level_nxt & ~level_r;

  // Edge state and registered pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= '0;
      rise_r  <= '0;
    end else begin
      level_r <= level_nxt;
      rise_r  <= rise_nxt;
    end
  end

  assign loss_rise = rise_r;

endmodule

// >>> rmf_top.sv
// Reference monitor failure status bank with AXI4-Lite register access.
// Assumes monitor fault inputs are synchronous to aclk; pins are not.
//
// Contract
// - Each reference owns four bits: loss, single cycle, coarse freq, soak.
// - Signal-loss flag sets when the reference's external loss input rises.
// - The loss input of each reference is routable from any general pin.
// - Single-cycle flag sets whenever its monitor reports a failure.
// - Coarse-frequency flag sets whenever its monitor reports a failure.
// - Soak flag sets whenever that reference's guard soak timer expires.
// - Status flags record failures regardless of any mask setting.
// - Mask bit 1 enables, 0 disables; low ref bits 3:0, high 7:4.
// - A cleared mask bit keeps its flag out of the interrupt status.
// - Index 0x07 holds refs 0 and 1, 0x06 refs 2 and 3, reset zero.
// - A set reference failure interrupt bit drives the interrupt line high while its enable at 0x04 is high.
// - Interrupt bit sets only with its enable at 0x04 high and a failure.

`timescale 1ns/100ps

module rmf_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address
  input  wire logic [rmf_pkg::AW-1:0]     awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // AXI4-Lite write response
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read address
  input  wire logic [rmf_pkg::AW-1:0]     araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  // AXI4-Lite read data
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Monitor events and pins
  input  wire logic [rmf_pkg::NGPIO-1:0]  gpio_in,
  input  wire logic [rmf_pkg::NREF-1:0]   single_cycle_fault,
  input  wire logic [rmf_pkg::NREF-1:0]   coarse_freq_fault,
  input  wire logic [rmf_pkg::NREF-1:0]   soak_expired,
  // Toward the interrupt logic
  output logic [rmf_pkg::NREF-1:0]        ref_fail_indicator,
  output logic                            irq
);

  localparam int NBIT = rmf_pkg::NREF * rmf_pkg::NFLAG;
  localparam int UL   = rmf_pkg::UPPER_PAIR_LSB;

  // ----------------------------------------------------------------
  // Address decoding shared by both bus directions
  // ----------------------------------------------------------------
  function automatic logic [rmf_pkg::IDXW-1:0] reg_index(input logic [rmf_pkg::AW-1:0] a);
    reg_index = a[rmf_pkg::IDXW+1:2];
  endfunction

  function automatic logic reg_mapped(input logic [rmf_pkg::AW-1:0] a);
    logic [rmf_pkg::IDXW-1:0] i;
    i = a[rmf_pkg::IDXW+1:2];
    reg_mapped = (a[1:0] == 2'b00) && (a[rmf_pkg::AW-1] == 1'b0) &&
                 (i == rmf_pkg::IDX_ISR_STATUS || i == rmf_pkg::IDX_ISR_MASK ||
                  i == rmf_pkg::IDX_STAT_UPPER || i == rmf_pkg::IDX_STAT_LOWER ||
                  i == rmf_pkg::IDX_MASK_UPPER || i == rmf_pkg::IDX_MASK_LOWER ||
                  i == rmf_pkg::IDX_PIN_SELECT);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NBIT-1:0]  stat_r;        // Sticky monitor flags, refs 0..3
  logic [NBIT-1:0]  stat_nxt;
  logic [NBIT-1:0]  mask_r;        // Indicator enables, same layout
  logic [NBIT-1:0]  mask_nxt;
  logic [3:0]       isr_r;         // Reference failure interrupt status
  logic [3:0]       isr_nxt;
  logic [3:0]       isr_mask_r;
  logic [3:0]       isr_mask_nxt;
  logic [11:0]      pinsel_r;
  logic [11:0]      pinsel_nxt;
  logic [3:0]       ind_nxt;
  logic [3:0]       ind_r;

  logic                      aw_held_r;
  logic                      w_held_r;
  logic [rmf_pkg::AW-1:0]    awaddr_r;
  logic [31:0]               wdata_r;
  logic [3:0]                wstrb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      rvalid_r;
  logic [1:0]                rresp_r;
  logic [31:0]               rdata_r;

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  logic [rmf_pkg::NREF-1:0] loss_rise;
  logic [NBIT-1:0]          ev;

  // Pin routing and synchronising live in their own module
  rmf_los_sel u_los_sel (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .gpio_in    (gpio_in),
    .pin_select (pinsel_r),
    .loss_rise  (loss_rise)
  );

  // Gather per-reference events into the flag layout
  genvar g;
  generate
    for (g = 0; g < rmf_pkg::NREF; g++) begin : g_ev
      assign ev[g*4 + rmf_pkg::FLAG_SIGNAL_LOSS]  = loss_rise[g];
      assign ev[g*4 + rmf_pkg::FLAG_SINGLE_CYCLE] = single_cycle_fault[g];
      assign ev[g*4 + rmf_pkg::FLAG_COARSE_FREQ]  = coarse_freq_fault[g];
      assign ev[g*4 + rmf_pkg::FLAG_SOAK_EXPIRED] = soak_expired[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  wire aw_hs  = awvalid & awready;
  wire w_hs   = wvalid & wready;
  wire ar_hs  = arvalid & arready;
  wire wr_go  = aw_held_r & w_held_r & ~bvalid_r;

  // One write in flight; address and data may arrive in either order
  assign awready = ~aw_held_r & ~bvalid_r;
  assign wready  = ~w_held_r & ~bvalid_r;
  assign arready = ~rvalid_r;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire [rmf_pkg::IDXW-1:0] widx   = reg_index(awaddr_r);
  wire                     wmap   = reg_mapped(awaddr_r);
  wire                     wlane0 = wr_go & wstrb_r[0];
  wire                     wlane1 = wr_go & wstrb_r[1];
  wire wr_mask_upper = wlane0 & (widx == rmf_pkg::IDX_MASK_UPPER);
  wire wr_mask_lower = wlane0 & (widx == rmf_pkg::IDX_MASK_LOWER);
  wire wr_isr_mask   = wlane0 & (widx == rmf_pkg::IDX_ISR_MASK);
  wire wr_pin_lo     = wlane0 & (widx == rmf_pkg::IDX_PIN_SELECT);
  wire wr_pin_hi     = wlane1 & (widx == rmf_pkg::IDX_PIN_SELECT);

  // Mask writes touch only the mask; flags are never gated by it
  assign mask_nxt[UL-1:0]    = wr_mask_lower ? wdata_r[7:0] : mask_r[UL-1:0];
  assign mask_nxt[NBIT-1:UL] = wr_mask_upper ? wdata_r[7:0] : mask_r[NBIT-1:UL];
  assign isr_mask_nxt        = wr_isr_mask ? wdata_r[3:0] : isr_mask_r;
  assign pinsel_nxt[7:0]     = wr_pin_lo ? wdata_r[7:0] : pinsel_r[7:0];
  assign pinsel_nxt[11:8]    = wr_pin_hi ? wdata_r[11:8] : pinsel_r[11:8];

  // ----------------------------------------------------------------
  // Read decode and clear-on-read
  // ----------------------------------------------------------------
  wire [rmf_pkg::IDXW-1:0] ridx = reg_index(araddr);
  wire                     rmap = reg_mapped(araddr);
  wire rd_stat_upper = ar_hs & rmap & (ridx == rmf_pkg::IDX_STAT_UPPER);
  wire rd_stat_lower = ar_hs & rmap & (ridx == rmf_pkg::IDX_STAT_LOWER);
  wire rd_isr        = ar_hs & rmap & (ridx == rmf_pkg::IDX_ISR_STATUS);

  wire [NBIT-1:0] stat_clr = {{8{rd_stat_upper}}, {8{rd_stat_lower}}};

  // Read data selection; unused upper bits read as zero
  wire [31:0] rd_word =
    (ridx == rmf_pkg::IDX_ISR_STATUS) ? {28'h000_0000, isr_r} :
    (ridx == rmf_pkg::IDX_ISR_MASK)   ? {28'h000_0000, isr_mask_r} :
    (ridx == rmf_pkg::IDX_STAT_UPPER) ? {24'h00_0000, stat_r[NBIT-1:UL]} :
    (ridx == rmf_pkg::IDX_STAT_LOWER) ? {24'h00_0000, stat_r[UL-1:0]} :
    (ridx == rmf_pkg::IDX_MASK_UPPER) ? {24'h00_0000, mask_r[NBIT-1:UL]} :
    (ridx == rmf_pkg::IDX_MASK_LOWER) ? {24'h00_0000, mask_r[UL-1:0]} :
    (ridx == rmf_pkg::IDX_PIN_SELECT) ? {20'h0_0000, pinsel_r} :
                                        32'h0000_0000;

  // ----------------------------------------------------------------
  // Sticky flags and interrupt status
  // ----------------------------------------------------------------
  // Set beats the read clear, so an event landing on the read survives
  assign stat_nxt = (stat_r & ~stat_clr) | ev;

  // Per-reference masked failure and interrupt event
  logic [3:0] isr_ev;
  generate
    for (g = 0; g < rmf_pkg::NREF; g++) begin : g_isr
      assign isr_ev[g]  = |(ev[g*4 +: 4] & mask_r[g*4 +: 4]) & isr_mask_r[g];
      assign ind_nxt[g] = |(stat_nxt[g*4 +: 4] & mask_nxt[g*4 +: 4]);
    end
  endgenerate

  assign isr_nxt = (isr_r & ~{4{rd_isr}}) | isr_ev;

  // Level line: any interrupt bit that is still enabled
  assign irq = |(isr_r & isr_mask_r);

  assign ref_fail_indicator = ind_r;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r     <= {rmf_pkg::RST_STATUS, rmf_pkg::RST_STATUS};
      mask_r     <= {rmf_pkg::RST_MON_MASK, rmf_pkg::RST_MON_MASK};
      isr_r      <= rmf_pkg::RST_ISR;
      isr_mask_r <= rmf_pkg::RST_ISR_MASK;
      pinsel_r   <= rmf_pkg::RST_PIN_SELECT;
      ind_r      <= '0;
    end else begin
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      isr_r      <= isr_nxt;
      isr_mask_r <= isr_mask_nxt;
      pinsel_r   <= pinsel_nxt;
      ind_r      <= ind_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write channel capture and response
  // ----------------------------------------------------------------
  // Address and data are parked until both are here, then committed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (aw_hs) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_hs) begin
        w_held_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Response waits on bready; unmapped words answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= rmf_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wmap ? rmf_pkg::RESP_OKAY : rmf_pkg::RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Data is captured at the address edge, the same edge that clears flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= rmf_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rmap ? rmf_pkg::RESP_OKAY : rmf_pkg::RESP_SLVERR;
      rdata_r  <= rmap ? rd_word : 32'h0000_0000;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;

endmodule

// >>> rmf_top_sva.sv
// Checker for the bus handshakes and responses of the failure bank.
// Assumes it is bound to rmf_top and sees only that module's ports.
`timescale 1ns/100ps
module rmf_top_sva (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic [rmf_pkg::AW-1:0]  awaddr,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic [1:0]              bresp,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [rmf_pkg::AW-1:0]  araddr,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [31:0]             rdata,
  input wire logic [1:0]              rresp,
  input wire logic                    rvalid,
  input wire logic                    rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] aw_q;
  // Remember the write address, the response must match its decode
  always_ff @(posedge aclk) begin
    if (awvalid && awready) begin
      aw_q <= awaddr;
    end
  end
  function automatic logic mapped(logic [7:0] a);
    return a inside {8'h08, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40};
  endfunction
  a_b_hold:     assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped early");
  a_r_hold:     assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped early");
  a_ar_block:   assert property (rvalid |-> !arready)
    else $error("Read address taken during answer");
  a_aw_block:   assert property (bvalid |-> !awready && !wready)
    else $error("Write taken during response");
  a_rd_answer:  assert property (arvalid && arready |=> rvalid)
    else $error("Read answer late");
  a_wr_answer:  assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("Write answer late");
  a_rd_unmap:   assert property (arvalid && arready && !mapped(araddr) |=>
    rresp == rmf_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("Unmapped read not refused");
  a_wr_resp:    assert property ($rose(bvalid) |->
    bresp == (mapped(aw_q) ? rmf_pkg::RESP_OKAY : rmf_pkg::RESP_SLVERR))
    else $error("Write response code wrong");
endmodule
bind rmf_top rmf_top_sva u_sva (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready);

// >>> rmf_phy_model.sv
// PHY side model: drives the loss-of-signal levels onto the pins.
// Assumes the bench asks for pin levels in step with aclk.
`timescale 1ns/100ps
module rmf_phy_model (
  input  wire logic [rmf_pkg::NGPIO-1:0] los_req,
  input  wire logic                      aclk,
  output logic      [rmf_pkg::NGPIO-1:0] gpio_in
);
  // Pins move a few ns off the edge, since a PHY is not clocked by aclk
  always @(posedge aclk) begin
    gpio_in <= #3 los_req;
  end
endmodule

// >>> test_ref_monitor_fail_status.sv
// Self-checking bench for the failure status and mask bank.
// Assumes rmf_top, the PHY model and the bound checker are compiled first.
`timescale 1ns/100ps
module test_ref_monitor_fail_status;
  localparam logic [7:0]  ADDRS [7] = '{8'h08, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40};
  localparam logic [31:0] RSTV [7]  = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h66, 32'h66, 32'h688};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0, los_req = '0, gpio_in;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0, scf = '0, cff = '0, soak = '0, ind;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  int          n_mismatch = 0, num_checks = 0;
  rmf_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .gpio_in, .single_cycle_fault(scf), .coarse_freq_fault(cff),
    .soak_expired(soak), .ref_fail_indicator(ind), .irq);
  rmf_phy_model phy (.los_req, .aclk, .gpio_in);
  // Clock, 10 ns period
  initial forever #5 aclk = ~aclk;
  // Watchdog, well past the expected run length
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Ready is read at the falling edge, so the release lands after the taking edge
  // Response ready starts low at random, so the slave must hold its answer a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic ta, tw, tb, hs;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= {2'b11, 1'($urandom_range(1, 0))};
    do begin
      @(negedge aclk);
      {ta, tw, tb} = {awvalid & awready, wvalid & wready, bvalid};
      hs = tb & bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= bready ? !hs : tb;
    end while (!hs);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr, hs;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= {1'b1, 1'($urandom_range(1, 0))};
    do begin
      @(negedge aclk);
      {ta, tr, d, r} = {arvalid & arready, rvalid, rdata, rresp};
      hs = tr & rready;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      rready <= rready ? !hs : tr;
    end while (!hs);
  endtask
  // One-cycle event on one monitor input
  task automatic pulse(input int r, input int f);
    @(posedge aclk);
    case (f)
      1: scf[r] <= 1'b1;
      2: cff[r] <= 1'b1;
      default: soak[r] <= 1'b1;
    endcase
    @(posedge aclk);
    {scf, cff, soak} <= '0;
  endtask
  function automatic logic [7:0] st_addr(int r);
    return (r < 2) ? 8'h1c : 8'h18;
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    logic [15:0] mk, e16;
    logic [11:0] sel;
    int          p, q;
    d = $urandom(52);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ADDRS[i], d, rs);
      chk(d, RSTV[i]);
    end
    rd(8'h04, d, rs);
    chk({30'h0, rs}, {30'h0, rmf_pkg::RESP_SLVERR});
    wr(8'h2c, 32'h0000_00ff, 4'hf, rs);
    chk({30'h0, rs}, {30'h0, rmf_pkg::RESP_SLVERR});
    mk = 16'($urandom);
    wr(8'h24, {24'h0, mk[7:0]}, 4'hf, rs);
    wr(8'h20, {24'h0, mk[15:8]}, 4'hf, rs);
    wr(8'h20, 32'h0000_0000, 4'h0, rs);
    rd(8'h20, d, rs);
    chk(d, {24'h0, mk[15:8]});
    // Every monitor kind on every reference, indicator against random masks
    for (int r = 0; r < 4; r++) begin
      for (int f = 1; f < 4; f++) begin
        pulse(r, f);
        repeat (2) @(negedge aclk);
        chk({28'h0, ind}, {28'h0, 4'(mk[4*r+f]) << r});
        rd(st_addr(r), d, rs);
        chk(d, 32'h1 << (4 * (r % 2) + f));
        rd(st_addr(r), d, rs);
        chk(d, 32'h0);
      end
    end
    // Loss pins routed to random references
    repeat (3) begin
      p = $urandom_range(7, 0);
      q = $urandom_range(3, 0);
      sel = 12'h688;
      sel[3*q+:3] = 3'(p);
      wr(8'h40, {20'h0, sel}, 4'h3, rs);
      rd(8'h40, d, rs);
      chk(d, {20'h0, sel});
      @(posedge aclk);
      los_req[p] <= 1'b1;
      repeat (8) @(posedge aclk);
      los_req <= '0;
      e16 = '0;
      for (int r = 0; r < 4; r++) e16[4*r] = (sel[3*r+:3] == 3'(p));
      rd(8'h1c, d, rs);
      chk(d, {24'h0, e16[7:0]});
      rd(8'h18, d, rs);
      chk(d, {24'h0, e16[15:8]});
    end
    // Interrupt raised, cleared, then blocked by each mask in turn
    wr(8'h24, 32'h0000_00ff, 4'hf, rs);
    wr(8'h10, 32'h0000_000f, 4'hf, rs);
    pulse(1, 2);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h08, d, rs);
    chk(d, 32'h2);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h1c, d, rs);
    chk(d, 32'h40);
    wr(8'h24, 32'h0000_00bf, 4'hf, rs);
    pulse(1, 2);
    rd(8'h08, d, rs);
    chk(d, 32'h0);
    rd(8'h1c, d, rs);
    chk(d, 32'h40);
    wr(8'h24, 32'h0000_00ff, 4'hf, rs);
    wr(8'h10, 32'h0000_000d, 4'hf, rs);
    pulse(1, 2);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, d, rs);
    chk(d, 32'h0);
    // Second reset in mid-run restores the masks
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h24, d, rs);
    chk(d, 32'h66);
    close_out();
  end
endmodule
